// ### inc/two_channel_bus_status_control_consts.svh
`ifndef TWO_CHANNEL_BUS_STATUS_CONTROL_CONSTS_SVH
`define TWO_CHANNEL_BUS_STATUS_CONTROL_CONSTS_SVH

// register pointer values carried in the low three bits of a command byte
`define REG_CH0_DATA_HI   3'h0
`define REG_CH0_DATA_LO   3'h1
`define REG_CH1_DATA_HI   3'h2
`define REG_CH1_DATA_LO   3'h3
`define REG_STATUS        3'h4
`define REG_CH0_CTRL      3'h5
`define REG_CH1_CTRL      3'h6
`define REG_ENABLE        3'h7

// command byte: msb selects write
`define CMD_WRITE_BIT     7

// reset values
`define CTRL_RESET        8'h00
`define STATUS_RESET      8'h66

// bit time is this many input clock periods, shifted left by the divider code
`define BIT_BASE_PERIODS  5'h3
// idle gap is this many bit times, shifted left by the gap code
`define GAP_BASE_BITS     6'h4

// fifo depth and input synchroniser length
`define FIFO_DEPTH        4
`define SYNC_STAGES       3

`endif

// ### inc/two_channel_bus_pkg.sv
`default_nettype none
package two_channel_bus_pkg;

  // per-channel control byte, msb first
  typedef struct packed {
    logic       spare;        // stored, no effect
    logic       short_msg;    // 1: 8 data bits, 0: 16 data bits
    logic       tx_irq_en;    // tx empty drives the interrupt
    logic       rx_irq_en;    // rx not empty drives the interrupt
    logic [1:0] frame_gap;    // idle bit times between frames
    logic [1:0] bit_divider;  // input clock periods per bit time
  } ctrl_t;

  // per-channel status nibble, msb first
  typedef struct packed {
    logic crc_error;
    logic tx_empty;
    logic tx_not_full;
    logic rx_not_empty;
  } chan_flags_t;

  // serial slave phases
  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_COMMAND,
    SPI_BURST
  } spi_state_t;

endpackage
`default_nettype wire

// ### rtl/two_channel_bus_status_control.sv
// Behaviour
// - status snapshot taken at chip select fall
// - later changes hidden until next select
// - data snapshot too; status returned first
// - each rx entry keeps its crc error
// - crc error flag raises no interrupt
// - tx empty flag; four writes fit
// - writes into full tx fifo discarded
// - rx not empty before tx not full
// - rx not empty while rx fifo occupied
// - tx write also pops rx fifo
// - control write aborts transfer in progress
// - control applied at next bit tick
// - divider gives 3, 6, 12, 24 periods
// - gap of 4, 8, 16, 32 bits
// - gap counted in current bit times
// - rx not empty with enable drives interrupt
// - tx empty with enable drives interrupt
// - short message selects 8 data bits
// - interrupt held while any condition pends
// - control write clears both fifos
// - fresh gap timed after abort
`timescale 1ns/1ps
`include "two_channel_bus_status_control_consts.svh"
`default_nettype none

module two_channel_bus_status_control
  import two_channel_bus_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                spi_sck,
  input  wire logic                spi_mosi,
  input  wire logic                spi_cs_b,
  output var  logic                spi_miso,
  output var  logic                spi_miso_oe_b,
  output var  logic                irq_out,
  output var  logic                irq_oe_b,
  input  wire logic                bit_clk_in,
  input  wire logic [1:0]          frame_end,
  input  wire logic [1:0]          frame_crc_err,
  input  wire logic [1:0][15:0]    rx_head_data,
  output var  logic [1:0]          bit_tick,
  output var  logic [1:0]          transfer_abort,
  output var  logic [1:0]          frame_gap_ok,
  output var  ctrl_t [1:0]         active_ctrl,
  output var  logic [1:0]          fifo_clear,
  output var  logic [1:0]          tx_push,
  output var  logic [15:0]         tx_word
);

  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // majority of the last two synchroniser stages, else hold
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  // input clock periods per bit time
  function automatic logic [4:0] bit_periods(input logic [1:0] code);
    bit_periods = `BIT_BASE_PERIODS << code;
  endfunction

  // idle bit times between frames
  function automatic logic [5:0] gap_bits(input logic [1:0] code);
    gap_bits = `GAP_BASE_BITS << code;
  endfunction

  // next pointer around the error ring
  function automatic logic [PTR_W-1:0] ring_next(input logic [PTR_W-1:0] p);
    ring_next = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // ---- pin synchronisers, stage 0 feeds stage 1 only
  logic [`SYNC_STAGES-1:0] sck_sync_q, mosi_sync_q, csb_sync_q, bclk_sync_q;
  logic [`SYNC_STAGES-1:0] sck_sync_d, mosi_sync_d, csb_sync_d, bclk_sync_d;
  logic                    sck_f_q, mosi_f_q, csb_f_q, bclk_f_q;  // filtered levels
  logic                    sck_f_d, mosi_f_d, csb_f_d, bclk_f_d;
  logic                    sck_rise, sck_fall, cs_fall, bclk_rise;

  // ---- serial slave state
  spi_state_t       state_q, state_d;
  logic [2:0]       bitcnt_q, bitcnt_d;      // bits left in byte
  logic [7:0]       shin_q, shin_d;          // receive shifter
  logic [7:0]       shout_q, shout_d;        // transmit shifter
  logic             miso_q, miso_d;
  logic             oe_b_q, oe_b_d;
  logic             wr_q, wr_d;              // burst is a write
  logic             first_q, first_d;        // first read byte pending
  logic [2:0]       ptr_q, ptr_d;            // register pointer
  logic [7:0]       stat_snap_q, stat_snap_d;
  logic [7:0]       data_snap_q [4];
  logic [7:0]       data_snap_d [4];
  logic [7:0]       tx_hi_q [2];             // high byte held until low write
  logic [7:0]       tx_hi_d [2];
  logic [15:0]      tx_word_q, tx_word_d;
  logic [1:0]       tx_push_q, tx_push_d;
  logic [1:0]       abort_q, abort_d;
  logic [7:0]       spi_byte;                // byte completing this cycle
  logic [1:0]       host_push, host_pop, ctrl_done;

  // ---- channel state
  ctrl_t            ctrl_q [2];              // stored as written
  ctrl_t            ctrl_d [2];
  ctrl_t [1:0]      act_q, act_d;            // settings in force
  logic [1:0]       apply_q, apply_d;        // stored settings await a tick
  logic [CNT_W-1:0] tx_cnt_q [2];
  logic [CNT_W-1:0] tx_cnt_d [2];
  logic [CNT_W-1:0] rx_cnt_q [2];
  logic [CNT_W-1:0] rx_cnt_d [2];
  logic [PTR_W-1:0] rx_rp_q [2];
  logic [PTR_W-1:0] rx_rp_d [2];
  logic [PTR_W-1:0] rx_wp_q [2];
  logic [PTR_W-1:0] rx_wp_d [2];
  logic [DEPTH-1:0] rx_err_q [2];            // crc error per entry
  logic [DEPTH-1:0] rx_err_d [2];
  logic [1:0]       pop_pend_q, pop_pend_d;  // tx pop waits one tick
  logic [4:0]       div_cnt_q [2];
  logic [4:0]       div_cnt_d [2];
  logic [1:0]       tick_q, tick_d;
  logic [5:0]       gap_cnt_q [2];
  logic [5:0]       gap_cnt_d [2];
  logic [1:0]       gap_ok_q, gap_ok_d;
  logic [1:0]       clear_q, clear_d;
  logic             irq_oe_b_q, irq_oe_b_d;
  chan_flags_t      flags [2];
  logic [7:0]       status_now;

  // ---- synchronisers and edge detection
  always_comb begin
    sck_sync_d  = {sck_sync_q[1:0], spi_sck};
    mosi_sync_d = {mosi_sync_q[1:0], spi_mosi};
    csb_sync_d  = {csb_sync_q[1:0], spi_cs_b};
    bclk_sync_d = {bclk_sync_q[1:0], bit_clk_in};
    sck_f_d     = filt(sck_sync_q, sck_f_q);
    mosi_f_d    = filt(mosi_sync_q, mosi_f_q);
    csb_f_d     = filt(csb_sync_q, csb_f_q);
    bclk_f_d    = filt(bclk_sync_q, bclk_f_q);
    sck_rise    = sck_f_d & ~sck_f_q;
    sck_fall    = ~sck_f_d & sck_f_q;
    cs_fall     = ~csb_f_d & csb_f_q;
    bclk_rise   = bclk_f_d & ~bclk_f_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_sync_q  <= '0;
      mosi_sync_q <= '0;
      csb_sync_q  <= '1;
      bclk_sync_q <= '0;
      sck_f_q     <= 1'b0;
      mosi_f_q    <= 1'b0;
      csb_f_q     <= 1'b1;
      bclk_f_q    <= 1'b0;
    end else begin
      sck_sync_q  <= sck_sync_d;
      mosi_sync_q <= mosi_sync_d;
      csb_sync_q  <= csb_sync_d;
      bclk_sync_q <= bclk_sync_d;
      sck_f_q     <= sck_f_d;
      mosi_f_q    <= mosi_f_d;
      csb_f_q     <= csb_f_d;
      bclk_f_q    <= bclk_f_d;
    end
  end

  // ---- live status, channel 1 in the high nibble
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      flags[ch].rx_not_empty = (rx_cnt_q[ch] != '0);
      flags[ch].crc_error    = flags[ch].rx_not_empty & rx_err_q[ch][rx_rp_q[ch]];
      flags[ch].tx_empty     = (tx_cnt_q[ch] == '0);
      flags[ch].tx_not_full  = (tx_cnt_q[ch] != CNT_W'(DEPTH));
    end
    status_now = {flags[1], flags[0]};
  end

  // ---- serial slave: command, burst, snapshots and register side effects
  always_comb begin
    state_d     = state_q;
    bitcnt_d    = bitcnt_q;
    shin_d      = shin_q;
    shout_d     = shout_q;
    miso_d      = miso_q;
    oe_b_d      = oe_b_q;
    wr_d        = wr_q;
    first_d     = first_q;
    ptr_d       = ptr_q;
    stat_snap_d = stat_snap_q;
    data_snap_d = data_snap_q;
    tx_hi_d     = tx_hi_q;
    tx_word_d   = tx_word_q;
    tx_push_d   = '0;
    abort_d     = abort_q;
    host_push   = '0;
    host_pop    = '0;
    ctrl_done   = '0;
    spi_byte    = {shin_q[6:0], mosi_f_d};
    if (csb_f_d) begin
      // deselected: release the data pin, drop any abort
      state_d = SPI_IDLE;
      oe_b_d  = 1'b1;
      abort_d = '0;
    end else if (cs_fall) begin
      // freeze status and data for the whole burst
      state_d        = SPI_COMMAND;
      bitcnt_d       = 3'h7;
      stat_snap_d    = status_now;
      data_snap_d[0] = rx_head_data[0][15:8];
      data_snap_d[1] = rx_head_data[0][7:0];
      data_snap_d[2] = rx_head_data[1][15:8];
      data_snap_d[3] = rx_head_data[1][7:0];
      miso_d         = status_now[7];
      shout_d        = {status_now[6:0], 1'b0};
      oe_b_d         = 1'b0;
    end else if (sck_rise) begin
      shin_d   = spi_byte;
      bitcnt_d = bitcnt_q - 3'h1;
      // a control byte under way holds its channel in abort
      abort_d[0] = (state_q == SPI_BURST) & wr_q & (ptr_q == `REG_CH0_CTRL);
      abort_d[1] = (state_q == SPI_BURST) & wr_q & (ptr_q == `REG_CH1_CTRL);
      if (bitcnt_q == 3'h0) begin
        bitcnt_d = 3'h7;
        if (state_q == SPI_COMMAND) begin
          // command byte: direction and start pointer
          state_d = SPI_BURST;
          wr_d    = spi_byte[`CMD_WRITE_BIT];
          ptr_d   = spi_byte[2:0];
          first_d = ~spi_byte[`CMD_WRITE_BIT];
          shout_d = stat_snap_q;
        end else if (wr_q) begin
          // data byte written at the pointer
          ptr_d = ptr_q + 3'h1;
          unique case (ptr_q)
            `REG_CH0_DATA_HI, `REG_CH1_DATA_HI: begin
              tx_hi_d[ptr_q[1]] = spi_byte;
            end
            `REG_CH0_DATA_LO, `REG_CH1_DATA_LO: begin
              host_pop[ptr_q[1]] = 1'b1;
              if (flags[ptr_q[1]].tx_not_full) begin
                host_push[ptr_q[1]] = 1'b1;
                tx_push_d[ptr_q[1]] = 1'b1;
                tx_word_d           = {tx_hi_q[ptr_q[1]], spi_byte};
              end
            end
            `REG_CH0_CTRL: begin
              ctrl_done[0] = 1'b1;
            end
            `REG_CH1_CTRL: begin
              ctrl_done[1] = 1'b1;
            end
            default: begin
              // status and enable writes have no effect here
            end
          endcase
        end else if (first_q) begin
          // snapshot status went out, pointer still unread
          first_d = 1'b0;
          shout_d = 8'h00;
        end else begin
          // read byte went out from the pointer
          ptr_d = ptr_q + 3'h1;
          if (ptr_q == `REG_CH0_DATA_LO || ptr_q == `REG_CH1_DATA_LO) begin
            host_pop[ptr_q[1]] = 1'b1;
          end
        end
        // load the next read byte
        if (state_q == SPI_BURST && !wr_q) begin
          unique case (ptr_d)
            `REG_STATUS:   shout_d = stat_snap_q;
            `REG_CH0_CTRL: shout_d = ctrl_q[0];
            `REG_CH1_CTRL: shout_d = ctrl_q[1];
            `REG_ENABLE:   shout_d = 8'h00;
            default:       shout_d = data_snap_q[ptr_d[1:0]];
          endcase
        end
        // byte complete: any abort ends with it
        abort_d = '0;
      end
    end else if (sck_fall) begin
      // present the next bit ahead of the master's sampling edge
      miso_d  = shout_q[7];
      shout_d = {shout_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= SPI_IDLE;
      bitcnt_q    <= 3'h7;
      shin_q      <= 8'h00;
      shout_q     <= 8'h00;
      miso_q      <= 1'b0;
      oe_b_q      <= 1'b1;
      wr_q        <= 1'b0;
      first_q     <= 1'b0;
      ptr_q       <= 3'h0;
      stat_snap_q <= `STATUS_RESET;
      data_snap_q <= '{default: 8'h00};
      tx_hi_q     <= '{default: 8'h00};
      tx_word_q   <= 16'h0000;
      tx_push_q   <= '0;
      abort_q     <= '0;
    end else begin
      state_q     <= state_d;
      bitcnt_q    <= bitcnt_d;
      shin_q      <= shin_d;
      shout_q     <= shout_d;
      miso_q      <= miso_d;
      oe_b_q      <= oe_b_d;
      wr_q        <= wr_d;
      first_q     <= first_d;
      ptr_q       <= ptr_d;
      stat_snap_q <= stat_snap_d;
      data_snap_q <= data_snap_d;
      tx_hi_q     <= tx_hi_d;
      tx_word_q   <= tx_word_d;
      tx_push_q   <= tx_push_d;
      abort_q     <= abort_d;
    end
  end

  // ---- channels: bit timing, gap, fifo occupancy, control apply
  always_comb begin
    ctrl_d     = ctrl_q;
    act_d      = act_q;
    apply_d    = apply_q;
    tx_cnt_d   = tx_cnt_q;
    rx_cnt_d   = rx_cnt_q;
    rx_rp_d    = rx_rp_q;
    rx_wp_d    = rx_wp_q;
    rx_err_d   = rx_err_q;
    pop_pend_d = pop_pend_q;
    div_cnt_d  = div_cnt_q;
    gap_cnt_d  = gap_cnt_q;
    tick_d     = '0;
    clear_d    = '0;
    irq_oe_b_d = 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      // bit time from input clock rising edges
      if (bclk_rise) begin
        if (div_cnt_q[ch] >= bit_periods(act_q[ch].bit_divider) - 5'h1) begin
          div_cnt_d[ch] = 5'h00;
          tick_d[ch]    = 1'b1;
        end else begin
          div_cnt_d[ch] = div_cnt_q[ch] + 5'h01;
        end
      end
      if (ctrl_done[ch]) begin
        // control written: store, empty both fifos, restart the gap later
        ctrl_d[ch]     = spi_byte;
        apply_d[ch]    = 1'b1;
        clear_d[ch]    = 1'b1;
        tx_cnt_d[ch]   = '0;
        rx_cnt_d[ch]   = '0;
        rx_rp_d[ch]    = '0;
        rx_wp_d[ch]    = '0;
        rx_err_d[ch]   = '0;
        pop_pend_d[ch] = 1'b0;
      end else begin
        // tx pop deferred from frame end to the following tick
        if (tick_q[ch] && pop_pend_q[ch]) begin
          pop_pend_d[ch] = 1'b0;
          tx_cnt_d[ch]   = tx_cnt_d[ch] - CNT_W'(1);
        end
        if (host_push[ch]) begin
          tx_cnt_d[ch] = tx_cnt_d[ch] + CNT_W'(1);
        end
        // host pop only takes a present entry; error follows the new head
        if (host_pop[ch] && rx_cnt_q[ch] != '0) begin
          rx_rp_d[ch]  = ring_next(rx_rp_q[ch]);
          rx_cnt_d[ch] = rx_cnt_d[ch] - CNT_W'(1);
        end
        if (tick_q[ch] && apply_q[ch]) begin
          // new settings take hold; a fresh full gap follows
          act_d[ch]     = ctrl_q[ch];
          apply_d[ch]   = 1'b0;
          gap_cnt_d[ch] = gap_bits(ctrl_q[ch].frame_gap);
        end else if (tick_q[ch] && gap_cnt_q[ch] != 6'h00) begin
          gap_cnt_d[ch] = gap_cnt_q[ch] - 6'h01;
        end
        if (frame_end[ch] && !abort_q[ch]) begin
          // rx entry lands now, tx slot frees one tick later
          if (rx_cnt_q[ch] != CNT_W'(DEPTH)) begin
            rx_err_d[ch][rx_wp_q[ch]] = frame_crc_err[ch];
            rx_wp_d[ch]  = ring_next(rx_wp_q[ch]);
            rx_cnt_d[ch] = rx_cnt_d[ch] + CNT_W'(1);
          end
          pop_pend_d[ch] = (tx_cnt_q[ch] != '0);
          gap_cnt_d[ch]  = gap_bits(act_q[ch].frame_gap);
        end
      end
      gap_ok_d[ch] = (gap_cnt_d[ch] == 6'h00) & ~apply_d[ch] & ~abort_d[ch];
      // crc error has no interrupt source of its own
      if ((act_q[ch].rx_irq_en && flags[ch].rx_not_empty) ||
          (act_q[ch].tx_irq_en && flags[ch].tx_empty)) begin
        irq_oe_b_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q     <= '{default: `CTRL_RESET};
      act_q      <= {`CTRL_RESET, `CTRL_RESET};
      apply_q    <= '0;
      tx_cnt_q   <= '{default: '0};
      rx_cnt_q   <= '{default: '0};
      rx_rp_q    <= '{default: '0};
      rx_wp_q    <= '{default: '0};
      rx_err_q   <= '{default: '0};
      pop_pend_q <= '0;
      div_cnt_q  <= '{default: 5'h00};
      gap_cnt_q  <= '{default: 6'h00};
      tick_q     <= '0;
      gap_ok_q   <= '0;
      clear_q    <= '0;
      irq_oe_b_q <= 1'b1;
    end else begin
      ctrl_q     <= ctrl_d;
      act_q      <= act_d;
      apply_q    <= apply_d;
      tx_cnt_q   <= tx_cnt_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_rp_q    <= rx_rp_d;
      rx_wp_q    <= rx_wp_d;
      rx_err_q   <= rx_err_d;
      pop_pend_q <= pop_pend_d;
      div_cnt_q  <= div_cnt_d;
      gap_cnt_q  <= gap_cnt_d;
      tick_q     <= tick_d;
      gap_ok_q   <= gap_ok_d;
      clear_q    <= clear_d;
      irq_oe_b_q <= irq_oe_b_d;
    end
  end

  // ---- outputs, all from flip-flops except irq_out, which is held at 0
  assign spi_miso       = miso_q;
  assign spi_miso_oe_b  = oe_b_q;
  assign irq_out        = 1'b0 & irq_oe_b_q;  // open drain only ever pulls low
  assign irq_oe_b       = irq_oe_b_q;
  assign bit_tick       = tick_q;
  assign transfer_abort = abort_q;
  assign frame_gap_ok   = gap_ok_q;
  assign active_ctrl    = act_q;
  assign fifo_clear     = clear_q;
  assign tx_push        = tx_push_q;
  assign tx_word        = tx_word_q;

endmodule

`default_nettype wire

// ### test/two_channel_bus_status_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the status and control block
module bus_ctrl_chk
  import two_channel_bus_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic             clk,
  input wire logic             rst_b,
  input wire logic             spi_sck,
  input wire logic             spi_mosi,
  input wire logic             spi_cs_b,
  input wire logic             spi_miso,
  input wire logic             spi_miso_oe_b,
  input wire logic             irq_out,
  input wire logic             irq_oe_b,
  input wire logic             bit_clk_in,
  input wire logic [1:0]       frame_end,
  input wire logic [1:0]       frame_crc_err,
  input wire logic [1:0][15:0] rx_head_data,
  input wire logic [1:0]       bit_tick,
  input wire logic [1:0]       transfer_abort,
  input wire logic [1:0]       frame_gap_ok,
  input wire ctrl_t [1:0]      active_ctrl,
  input wire logic [1:0]       fifo_clear,
  input wire logic [1:0]       tx_push,
  input wire logic [15:0]      tx_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // channel 0 control byte has just finished
  sequence wr_done0;
    $fell(transfer_abort[0]);
  endsequence
  // no interrupt enable in force for two cycles
  sequence en_off;
    (active_ctrl[0][5:4] == 2'h0 && active_ctrl[1][5:4] == 2'h0) [*2];
  endsequence
  clear_at_end_a: assert property (wr_done0 |-> fifo_clear[0])
    else $error("no fifo clear after control write");
  clear_cause_a: assert property (fifo_clear[1] |-> $past(transfer_abort[1]))
    else $error("fifo clear without control write");
  ctrl_hold_a: assert property (transfer_abort[0] |=> $stable(active_ctrl[0]))
    else $error("control applied during write");
  apply_tick_a: assert property ($changed(active_ctrl[1]) |-> $past(bit_tick[1]))
    else $error("control applied off the bit tick");
  gap_reset_a: assert property (transfer_abort[0] |=> !frame_gap_ok[0])
    else $error("gap reported during abort");
  irq_quiet_a: assert property (en_off |=> irq_oe_b)
    else $error("interrupt with enables off");
  irq_tx_a: assert property ($rose(active_ctrl[0].tx_irq_en) |-> ##[1:2] !irq_oe_b)
    else $error("tx empty interrupt missing");
  miso_idle_a: assert property (spi_cs_b [*6] |-> spi_miso_oe_b)
    else $error("miso driven while deselected");
endmodule
bind two_channel_bus_status_control bus_ctrl_chk #(.DEPTH(DEPTH)) chk_i (
  .clk(clk), .rst_b(rst_b), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_cs_b(spi_cs_b),
  .spi_miso(spi_miso), .spi_miso_oe_b(spi_miso_oe_b), .irq_out(irq_out),
  .irq_oe_b(irq_oe_b), .bit_clk_in(bit_clk_in), .frame_end(frame_end),
  .frame_crc_err(frame_crc_err), .rx_head_data(rx_head_data), .bit_tick(bit_tick),
  .transfer_abort(transfer_abort), .frame_gap_ok(frame_gap_ok), .active_ctrl(active_ctrl),
  .fifo_clear(fifo_clear), .tx_push(tx_push), .tx_word(tx_word));
`default_nettype wire

// ### test/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host spi master, mode 0, half period of eight system clocks
module spi_host_model (
  input  wire logic clk,
  output var  logic sck,
  output var  logic mosi,
  output var  logic cs_b,
  input  wire logic miso,
  input  wire logic miso_oe_b
);
  logic last_q = 1'h0;  // last driven miso level
  // a released line shows the inverse of its last value
  wire line = miso_oe_b ? ~last_q : miso;
  initial begin
    sck = 1'h0;
    mosi = 1'h0;
    cs_b = 1'h1;
  end
  always @(posedge clk) if (!miso_oe_b) last_q <= miso;
  // select or deselect; a burst keeps select low throughout
  task automatic sel(input logic on);
    repeat (8) @(posedge clk);
    cs_b <= !on;
    repeat (8) @(posedge clk);
  endtask
  // one byte msb first, miso taken at each rising sck
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      mosi <= tx[i];
      repeat (7) @(posedge clk);
      rx[i] = line;
      sck <= 1'h1;
      repeat (8) @(posedge clk);
      sck <= 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// ### test/two_channel_bus_status_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// random and corner stimulus for the status and control block
module two_channel_bus_status_control_tb_top;
  import two_channel_bus_pkg::*;
  localparam int BCP = 6;  // system clocks per bit clock period
  logic             clk = 1'h0;
  logic             rst_b = 1'h0;
  logic             bit_clk_in = 1'h0;
  logic [1:0]       frame_end = 2'h0;
  logic [1:0]       frame_crc_err = 2'h0;
  logic [1:0][15:0] rx_head_data = 32'h0;
  wire              sck, mosi, cs_b, miso, miso_oe_b, irq_out, irq_oe_b;
  logic [1:0]       bit_tick, transfer_abort, frame_gap_ok, fifo_clear, tx_push;
  ctrl_t [1:0]      active_ctrl;
  logic [15:0]      tx_word;
  logic [31:0]      seed = 32'hE52D2817;  // fixed lfsr start
  logic [7:0]       rd, r2, c;
  int               n_mismatch = 0, n_compared = 0, pushes = 0, gap_n = 0, bc = 0;
  `define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin n_mismatch++; \
    $display("unexpected at %0t got %h want %h", $time, g, w); end end
  always #50 clk = ~clk;
  // bit clock, push count and ticks since the last channel 0 frame end
  always @(posedge clk) begin
    bc <= (bc == BCP - 1) ? 0 : bc + 1;
    bit_clk_in <= (bc < BCP / 2);
    pushes <= pushes + int'(tx_push[0]);
    gap_n <= frame_end[0] ? 0 : gap_n + int'(bit_tick[0]);
  end
  two_channel_bus_status_control dut (
    .clk(clk), .rst_b(rst_b), .spi_sck(sck), .spi_mosi(mosi), .spi_cs_b(cs_b),
    .spi_miso(miso), .spi_miso_oe_b(miso_oe_b), .irq_out(irq_out), .irq_oe_b(irq_oe_b),
    .bit_clk_in(bit_clk_in), .frame_end(frame_end), .frame_crc_err(frame_crc_err),
    .rx_head_data(rx_head_data), .bit_tick(bit_tick), .transfer_abort(transfer_abort),
    .frame_gap_ok(frame_gap_ok), .active_ctrl(active_ctrl), .fifo_clear(fifo_clear),
    .tx_push(tx_push), .tx_word(tx_word));
  spi_host_model host (.clk(clk), .sck(sck), .mosi(mosi), .cs_b(cs_b), .miso(miso),
    .miso_oe_b(miso_oe_b));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bit time in system clocks for a divider code
  function automatic int tick_len(input int d);
    return (3 << d) * BCP;
  endfunction
  task automatic results;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one burst: command, then n bytes of d high first; last byte read kept
  task automatic burst(input logic [7:0] cmd, input logic [15:0] d, input int n);
    host.sel(1'h1);
    host.xfer(cmd, rd);
    for (int i = n - 1; i >= 0; i--) host.xfer(d[8*i +: 8], rd);
    host.sel(1'h0);
  endtask
  // clocks up to the next bit tick, bounded
  task automatic wait_tick(input int ch, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (bit_tick[ch] !== 1'h1 && k < 400);
    if (k >= 400) begin n_mismatch++; results(); end
  endtask
  // one-cycle frame end from the serial engine
  task automatic frame(input int ch, input logic err);
    frame_end[ch] <= 1'h1;
    frame_crc_err[ch] <= err;
    @(posedge clk);
    frame_end[ch] <= 1'h0;
  endtask
  initial begin
    int k;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK(irq_oe_b, 1'h1)
    `CHK(irq_out, 1'h0)
    burst(8'h04, 16'h0, 1);
    `CHK(rd, 8'h66)
    burst(8'h86, 16'h4D, 1);
    wait_tick(1, k);
    wait_tick(1, k);
    `CHK(active_ctrl[1], 8'h4D)
    // every divider code, random gap code
    for (int d = 0; d < 4; d++) begin
      c = {2'h0, d[0], 1'h0, seed[1:0], d[1:0]};
      seed = lfsr(seed);
      burst(8'h85, {8'h0, c}, 1);
      wait_tick(0, k);
      wait_tick(0, k);
      `CHK(active_ctrl[0], c)
      `CHK(irq_oe_b, !d[0])
      wait_tick(0, k);
      `CHK(k, tick_len(d))
    end
    // fifth word must be dropped
    for (int p = 0; p < 5; p++) begin
      burst(8'h80, seed[15:0], 2);
      if (p < 4) `CHK(tx_word, seed[15:0])
      seed = lfsr(seed);
    end
    `CHK(pushes, 4)
    burst(8'h04, 16'h0, 1);
    `CHK(rd, 8'h60)
    wait_tick(0, k);
    frame(0, 1'h1);
    burst(8'h04, 16'h0, 1);
    `CHK(rd, 8'h69)
    `CHK(irq_oe_b, 1'h1)
    k = 0;
    while (frame_gap_ok[0] !== 1'h1 && k < 6000) begin @(posedge clk); k++; end
    if (k >= 6000) begin n_mismatch++; results(); end
    `CHK((gap_n >= (4 << c[3:2])) && (gap_n <= (4 << c[3:2]) + 1), 1'h1)
    // a frame inside a burst stays hidden
    host.sel(1'h1);
    host.xfer(8'h04, rd);
    frame(1, 1'h0);
    host.xfer(8'h0, r2);
    frame(0, 1'h0);
    host.xfer(8'h0, rd);
    host.sel(1'h0);
    `CHK(r2, 8'h6B)
    `CHK(rd, r2)
    wait_tick(0, k);
    wait_tick(0, k);
    burst(8'h04, 16'h0, 1);
    `CHK(rd, 8'h7B)
    burst(8'h80, seed[15:0], 2);
    burst(8'h04, 16'h0, 1);
    `CHK(rd, 8'h73)
    // data bytes come from the select-time snapshot
    seed = lfsr(seed);
    rx_head_data <= seed;
    burst(8'h01, 16'h0, 2);
    `CHK(rd, seed[7:0])
    results();
  end
endmodule
`default_nettype wire
